// *** hw/host_bus_interface_unit.sv ***
/*
  host bus interface unit: asynchronous strobe cycles, local-bus style
  synchronous cycles and burst cycles onto one internal request port.
  assumes bus pins are synchronous to clk, which also serves as bus clock,
  and that the queue side answers each request with core_ack.
*/
// Operation
// - ready_return_n ends local-bus cycles; in burst it is the system wait request.
// - async_ready goes low while the device needs time in a strobe cycle.
// - address, qualifier and lane enables latch on address strobe rise; transparent low.
// - local_select_n is a combinational match of qualifier and A15..A4 to base.
// - local decode only works while the address qualifier is low.
// - asynchronous transfers carry exactly one data item.
// - read data taken by host at read rise; write data captured at write rise.
// - data port select bypasses decode, forces 32-bit data port access only.
// - async_ready drops at the read strobe leading edge and releases when done; a write strobe only waits while a cycle is busy.
// - static cycle_style_sel: low local-bus style, high burst.
// - local-bus style: no bursts, latched decode, sample direction at cycle strobe.
// - local-bus style: write_read_sel high is write, low is read.
// - device asserts sync_ready_n; host answers ready_return_n after taking data.
// - local-bus read data stays driven until ready_return_n is seen.
// - burst: system stalls with ready_return_n, device with sync_ready_n.
// - 8-bit bus: lane 1 enable is the inverse of lane 0 enable.
// - sixteen locations decoded from A15..A4; byte, word, double word accesses.
// - lane enable patterns select 32-bit, half or single byte lanes.
// - on 8- and 16-bit buses the upper half is word swapped onto the low lanes; bytes never swapped.
// - local-bus style driven by clock, strobes and direction; waits via sync_ready_n.
// - lane enables ignored while data port select is low.
module host_bus_interface_unit
  import host_bus_pkg::*;
(
  input  wire logic                         clk,
  input  wire logic                         arst_n,
  input  wire logic [host_bus_pkg::BASE_W-1:0] base_addr,
  input  wire host_bus_pkg::bus_width_t     bus_width,
  input  wire logic                         cycle_style_sel,
  input  wire logic [host_bus_pkg::ADDR_HI:1] address,
  input  wire logic                         address_qualifier,
  input  wire logic [host_bus_pkg::LANES-1:0] byte_lane_enable_n,
  input  wire logic                         address_strobe_n,
  input  wire logic                         data_port_select_n,
  input  wire logic                         async_read_strobe_n,
  input  wire logic                         async_write_strobe_n,
  input  wire logic                         cycle_strobe_n,
  input  wire logic                         write_read_sel,
  input  wire logic                         ready_return_n,
  input  wire logic [host_bus_pkg::DATA_W-1:0] data_in,
  output logic      [host_bus_pkg::DATA_W-1:0] data_out,
  output logic                              data_oe,
  output logic                              local_select_n,
  output logic                              async_ready,
  output logic                              sync_ready_n,
  output logic                              core_req,
  output host_bus_pkg::core_req_t           core_cmd,
  input  wire logic                         core_ack,
  input  wire logic [host_bus_pkg::DATA_W-1:0] core_rdata
);
  import host_bus_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_A_RD,
    ST_A_HOLD,
    ST_A_WR,
    ST_S_REQ,
    ST_S_RDY,
    ST_B_REQ,
    ST_B_RDY
  } state_t;

  state_t state;
  core_req_t cur;
  logic [ADDR_HI:1]   addr_hold;
  logic               qual_hold;
  logic [LANES-1:0]   be_hold;
  logic [ADDR_HI:1]   addr_l;
  logic               qual_l;
  logic [LANES-1:0]   be_l;
  logic               hit;
  logic               rd_prev;
  logic               wr_prev;
  logic               wr_rise;
  logic               burst_rd;
  logic               burst_wr;
  logic               burst_act;
  core_req_t          next_cmd;

  // ----------------------------------------------------------------
  // address latch, transparent while the strobe is low
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_hold <= '0;
      qual_hold <= 1'b1;
      be_hold   <= BE_NONE_N;
    end else if (!address_strobe_n) begin
      addr_hold <= address;
      qual_hold <= address_qualifier;
      be_hold   <= byte_lane_enable_n;
    end
  end

  assign addr_l = address_strobe_n ? addr_hold : address;
  assign qual_l = address_strobe_n ? qual_hold : address_qualifier;
  assign be_l   = address_strobe_n ? be_hold : byte_lane_enable_n;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // a high qualifier marks memory or dma traffic, never a local decode match (data port select still hits)
  assign local_select_n = !(!qual_l && addr_l[ADDR_HI:DEC_LO] == base_addr);
  assign hit = !data_port_select_n || !local_select_n;

  // ----------------------------------------------------------------
  // lane mapping: word swap for narrow buses, never a byte swap
  // ----------------------------------------------------------------
  always_comb begin
    logic [LANES-1:0] be_n;
    be_n = be_l;
    next_cmd.wr    = 1'b0;
    next_cmd.dport = !data_port_select_n;
    next_cmd.idx   = {1'b0, addr_l[DEC_LO-1:2]};
    next_cmd.wdata = data_in;
    if (bus_width == BUS_W8) begin
      be_n = {BE_HI_N, !be_l[0], be_l[0]};
    end else if (bus_width == BUS_W16) begin
      be_n = {BE_HI_N, be_l[1:0]};
    end
    next_cmd.be = ~be_n;
    if (bus_width != BUS_W32 && addr_l[HALF_BIT]) begin
      next_cmd.be    = {~be_n[1:0], 2'h0};
      next_cmd.wdata = {data_in[HALF_W-1:0], data_in[HALF_W-1:0]};
    end
    if (!data_port_select_n) begin
      next_cmd.be    = BE_ALL;
      next_cmd.idx   = DPORT_IDX;
      next_cmd.wdata = data_in;
    end
  end

  function automatic logic [DATA_W-1:0] lane_out(input logic [DATA_W-1:0] d,
                                                 input logic hi);
    lane_out = d;
    if (hi) begin
      lane_out = {d[DATA_W-1:HALF_W], d[DATA_W-1:HALF_W]};
    end
  endfunction : lane_out

  // ----------------------------------------------------------------
  // strobe sampling
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_prev <= 1'b1;
      wr_prev <= 1'b1;
    end else begin
      rd_prev <= async_read_strobe_n;
      wr_prev <= async_write_strobe_n;
    end
  end

  assign wr_rise   = async_write_strobe_n && !wr_prev;
  // burst commands are the system read and write commands, active low
  assign burst_rd  = cycle_style_sel && !write_read_sel;
  assign burst_wr  = cycle_style_sel && !cycle_strobe_n;
  assign burst_act = (burst_rd || burst_wr) && hit;

  // ----------------------------------------------------------------
  // cycle sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (!async_read_strobe_n && rd_prev && hit) begin
            state <= ST_A_RD;
          end else if (wr_rise && hit) begin
            state <= ST_A_WR;
          end else if (!cycle_style_sel && !cycle_strobe_n && hit) begin
            state <= ST_S_REQ;
          end else if (burst_act) begin
            state <= burst_wr ? ST_B_RDY : ST_B_REQ;
          end
        end
        ST_A_RD: begin
          if (core_ack) begin
            state <= ST_A_HOLD;
          end
        end
        ST_A_HOLD: begin
          if (async_read_strobe_n) begin
            state <= ST_IDLE;
          end
        end
        ST_A_WR: begin
          if (core_ack) begin
            state <= ST_IDLE;
          end
        end
        ST_S_REQ: begin
          if (core_ack) begin
            state <= ST_S_RDY;
          end
        end
        ST_S_RDY: begin
          if (!ready_return_n) begin
            state <= ST_IDLE;
          end
        end
        ST_B_REQ: begin
          if (core_ack) begin
            state <= (cur.wr && !burst_act) ? ST_IDLE : ST_B_RDY;
          end
        end
        ST_B_RDY: begin
          if (!burst_act) begin
            state <= ST_IDLE;
          end else if (ready_return_n) begin
            state <= ST_B_REQ;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // request register: captured when a cycle starts; a burst write beat retakes only the write data
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cur <= '0;
    end else if (state == ST_IDLE) begin
      cur    <= next_cmd;
      // a strobe read must not pick up the idle level of the direction pin
      cur.wr <= async_read_strobe_n
                && (wr_rise || (!cycle_style_sel && write_read_sel) || burst_wr);
    end else if (state == ST_B_RDY && burst_act && ready_return_n && cur.wr) begin
      cur.wdata <= next_cmd.wdata;
    end
  end

  assign core_req = state == ST_A_RD || state == ST_A_WR || state == ST_S_REQ
                    || state == ST_B_REQ;
  assign core_cmd = cur;

  // ----------------------------------------------------------------
  // read data drive
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      data_out <= '0;
      data_oe  <= 1'b0;
    end else if (core_req && core_ack && !cur.wr) begin
      data_out <= lane_out(core_rdata, bus_width != BUS_W32 && !cur.dport
                           && cur.be[1:0] == 2'h0);
      data_oe  <= 1'b1;
    end else if (state == ST_A_HOLD && async_read_strobe_n) begin
      data_oe  <= 1'b0;
    end else if (state == ST_S_RDY && !ready_return_n) begin
      data_oe  <= 1'b0;
    end else if (state == ST_B_RDY && (!burst_act || ready_return_n)) begin
      data_oe  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // ready outputs
  // ----------------------------------------------------------------
  // combinational so the wait level is there from the leading edge
  assign async_ready = !((!async_read_strobe_n && hit && state != ST_A_HOLD)
                         || (!async_write_strobe_n && hit && state != ST_IDLE));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_ready_n <= 1'b1;
    end else if ((state == ST_S_REQ || (state == ST_B_REQ && (!cur.wr || burst_act)))
                 && core_ack) begin
      sync_ready_n <= 1'b0;
    end else if (state == ST_IDLE && burst_wr && hit) begin
      sync_ready_n <= 1'b0;
    end else if ((state == ST_S_RDY && !ready_return_n)
                 || (state == ST_B_RDY && (!burst_act || ready_return_n))) begin
      sync_ready_n <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence seq_rd_lead;
    $fell(async_read_strobe_n) && hit;
  endsequence

  sequence seq_lb_done;
    state == ST_S_RDY && !ready_return_n;
  endsequence

  chk_qual_blocks_decode: assert property (@(posedge clk) disable iff (!arst_n)
    qual_l |-> local_select_n)
    else $error("decode active with qualifier high");

  chk_async_wait_lead: assert property (@(posedge clk) disable iff (!arst_n)
    seq_rd_lead |-> !async_ready)
    else $error("async ready not low at read leading edge");

  chk_async_release: assert property (@(posedge clk) disable iff (!arst_n)
    state == ST_A_RD && core_ack |=> async_ready && data_oe)
    else $error("async read not released after data");

  chk_lb_data_hold: assert property (@(posedge clk) disable iff (!arst_n)
    state == ST_S_RDY && data_oe && ready_return_n |=> data_oe)
    else $error("read data dropped before ready return");

  chk_lb_end: assert property (@(posedge clk) disable iff (!arst_n)
    seq_lb_done |=> sync_ready_n && state == ST_IDLE && !data_oe)
    else $error("local bus cycle did not end");

  chk_dport_full: assert property (@(posedge clk) disable iff (!arst_n)
    core_req && cur.dport |-> cur.be == BE_ALL && cur.idx == DPORT_IDX)
    else $error("data port access not full width");

  chk_burst_stall: assert property (@(posedge clk) disable iff (!arst_n)
    state == ST_B_RDY && burst_act && !ready_return_n |=> state == ST_B_RDY
    && !sync_ready_n)
    else $error("burst beat ended during system wait");

  chk_latch_hold: assert property (@(posedge clk) disable iff (!arst_n)
    address_strobe_n && $past(address_strobe_n) |-> $stable(addr_hold))
    else $error("latched address moved while strobe high");

  chk_wr_capture: assert property (@(posedge clk) disable iff (!arst_n)
    state == ST_IDLE && wr_rise && hit |=> state == ST_A_WR && cur.wr)
    else $error("write data not captured at strobe rise");

endmodule : host_bus_interface_unit

// *** hw/host_bus_pkg.sv ***
/*
  shared types and constants of the host bus unit.
  assumes one clock domain; bus pins are already synchronous to it.
*/
package host_bus_pkg;

  // ----------------------------------------------------------------
  // address and lane layout
  // ----------------------------------------------------------------
  localparam int ADDR_HI  = 15;
  localparam int DEC_LO   = 4;
  localparam int BASE_W   = ADDR_HI - DEC_LO + 1;
  localparam int IDX_W    = 3;
  localparam int HALF_BIT = 1;
  localparam int DATA_W   = 32;
  localparam int HALF_W   = 16;
  localparam int LANES    = 4;

  localparam logic [LANES-1:0] BE_ALL_N  = 4'h0;
  localparam logic [LANES-1:0] BE_NONE_N = 4'hF;
  localparam logic [LANES-1:0] BE_ALL    = 4'hF;
  localparam logic [1:0]       BE_HI_N   = 2'h3;
  localparam logic [IDX_W-1:0] DPORT_IDX = 3'h4;

  typedef enum logic [1:0] {
    BUS_W8,
    BUS_W16,
    BUS_W32
  } bus_width_t;

  typedef struct packed {
    logic              wr;
    logic              dport;
    logic [IDX_W-1:0]  idx;
    logic [LANES-1:0]  be;
    logic [DATA_W-1:0] wdata;
  } core_req_t;

endpackage : host_bus_pkg

// *** test/host_model.sv ***
/*
  host side model: strobe cycles, local-bus cycles and one burst read.
  assumes the caller keeps cycles apart; pins change at the falling edge.
*/
module host_model
  import host_bus_pkg::*;
(
  input  wire logic                          clk,
  input  wire logic [host_bus_pkg::DATA_W-1:0] data_out,
  input  wire logic                          data_oe,
  input  wire logic                          async_ready,
  input  wire logic                          sync_ready_n,
  output logic [host_bus_pkg::ADDR_HI:1]     address,
  output logic                               address_qualifier,
  output logic [host_bus_pkg::LANES-1:0]     byte_lane_enable_n,
  output logic                               address_strobe_n,
  output logic                               data_port_select_n,
  output logic                               async_read_strobe_n,
  output logic                               async_write_strobe_n,
  output logic                               cycle_strobe_n,
  output logic                               write_read_sel,
  output logic                               ready_return_n,
  output logic [host_bus_pkg::DATA_W-1:0]    data_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // idle levels
  // ----------------------------------------------------------------
  // one cycle kind at a time, the other kind's pins idle
  initial begin
    address = '0;
    address_qualifier = 1'b1;
    byte_lane_enable_n = BE_NONE_N;
    address_strobe_n = 1'b0;
    data_port_select_n = 1'b1;
    async_read_strobe_n = 1'b1;
    async_write_strobe_n = 1'b1;
    cycle_strobe_n = 1'b1;
    write_read_sel = 1'b1;
    ready_return_n = 1'b1;
    data_in = 32'h5A5A_A5A5;
  end

  // ----------------------------------------------------------------
  // cycles
  // ----------------------------------------------------------------
  task automatic sel(input logic [ADDR_HI:1] a, input logic q, input logic [LANES-1:0] b,
                     input logic dp);
    @(negedge clk);
    address = a;
    address_qualifier = q;
    byte_lane_enable_n = b;
    data_port_select_n = dp;
  endtask : sel

  task automatic strobe(input logic v);
    @(negedge clk);
    address_strobe_n = v;
  endtask : strobe

  task automatic arw(input logic wr, input logic [DATA_W-1:0] wd,
                     output logic [DATA_W-1:0] rd, output logic waited, output logic ok);
    ok = 0;
    waited = 0;
    repeat (2) @(negedge clk);
    data_in = wr ? wd : ~wd;
    if (wr) async_write_strobe_n = 0; else async_read_strobe_n = 0;
    for (int i = 0; i < 40 && !ok; i++) begin
      @(negedge clk);
      if (!async_ready) waited = 1;
      ok = async_ready && (wr ? i > 0 : data_oe);
    end
    rd = data_out;
    async_read_strobe_n = 1;
    async_write_strobe_n = 1;
  endtask : arw

  // cycle strobe one clock after address strobe, ack after taking data
  task automatic lbx(input logic wr, input logic [DATA_W-1:0] wd,
                     output logic [DATA_W-1:0] rd, output logic held, output logic ok);
    ok = 0;
    @(negedge clk);
    address_strobe_n = 0;
    @(negedge clk);
    address_strobe_n = 1;
    cycle_strobe_n = 0;
    write_read_sel = wr;
    data_in = wr ? wd : ~wd;
    @(negedge clk);
    cycle_strobe_n = 1;
    for (int i = 0; i < 40 && !ok; i++) begin
      if (!sync_ready_n) ok = 1; else @(negedge clk);
    end
    rd = data_out;
    repeat (2) @(negedge clk);
    held = !sync_ready_n && data_out === rd && (wr || data_oe);
    ready_return_n = 0;
    @(negedge clk);
    ready_return_n = 1;
    write_read_sel = 1;
    address_strobe_n = 0;
    @(negedge clk);
    ok = ok && sync_ready_n;
  endtask : lbx

  // read command low, system stalls two clocks on the first beat
  task automatic brd(output logic [DATA_W-1:0] rd, output logic held, output logic ok);
    ok = 0;
    @(negedge clk);
    write_read_sel = 0;
    for (int i = 0; i < 40 && !ok; i++) begin
      @(negedge clk);
      ok = !sync_ready_n;
    end
    ready_return_n = 0;
    rd = data_out;
    repeat (2) @(negedge clk);
    held = !sync_ready_n && data_out === rd;
    ready_return_n = 1;
    @(negedge clk);
    write_read_sel = 1;
  endtask : brd
endmodule : host_model

// *** test/tb.sv ***
/*
  self-checking bench of the host bus unit with a host model and a core responder.
  assumes the design answers within the bounded waits below.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import host_bus_pkg::*;

  localparam logic [BASE_W-1:0] BASE = 12'hA5C;
  localparam logic [DATA_W-1:0] RPAT = 32'h1234_5678;
  logic clk, arst_n, cycle_style_sel, qual, asn, dsn, rsn, wsn, csn, wrs, rrn;
  logic data_oe, local_select_n, async_ready, sync_ready_n, core_req, core_ack = 0;
  bus_width_t bus_width;
  logic [ADDR_HI:1] address;
  logic [LANES-1:0] ben;
  logic [DATA_W-1:0] data_in, data_out, rd;
  core_req_t core_cmd, last_cmd;
  logic w, ok;
  int acks = 0, ack_wait = 0, miscompares = 0, compares = 0;

  host_bus_interface_unit dut (.clk(clk), .arst_n(arst_n), .base_addr(BASE),
    .bus_width(bus_width), .cycle_style_sel(cycle_style_sel), .address(address),
    .address_qualifier(qual), .byte_lane_enable_n(ben), .address_strobe_n(asn),
    .data_port_select_n(dsn), .async_read_strobe_n(rsn), .async_write_strobe_n(wsn),
    .cycle_strobe_n(csn), .write_read_sel(wrs), .ready_return_n(rrn), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .local_select_n(local_select_n),
    .async_ready(async_ready), .sync_ready_n(sync_ready_n), .core_req(core_req),
    .core_cmd(core_cmd), .core_ack(core_ack), .core_rdata(RPAT));
  host_model h (.clk(clk), .data_out(data_out), .data_oe(data_oe), .async_ready(async_ready),
    .sync_ready_n(sync_ready_n), .address(address), .address_qualifier(qual),
    .byte_lane_enable_n(ben), .address_strobe_n(asn), .data_port_select_n(dsn),
    .async_read_strobe_n(rsn), .async_write_strobe_n(wsn), .cycle_strobe_n(csn),
    .write_read_sel(wrs), .ready_return_n(rrn), .data_in(data_in));

  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // core responder: two clocks of latency so the wait states show
  // ----------------------------------------------------------------
  always @(negedge clk) begin
    if (core_ack) begin
      core_ack <= 0;
    end else if (core_req === 1'b1 && ack_wait == 2) begin
      core_ack <= 1;
      last_cmd <= core_cmd;
      acks <= acks + 1;
      ack_wait <= 0;
    end else if (core_req === 1'b1) begin
      ack_wait <= ack_wait + 1;
    end
  end

  // ----------------------------------------------------------------
  // checks and closing
  // ----------------------------------------------------------------
  task automatic conclude;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude

  task automatic chk_word(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_word

  task automatic chk_bit(input logic g, input logic e);
    chk_word({31'h0, g}, {31'h0, e});
  endtask : chk_bit

  // a bound that runs out ends the run at once
  task automatic okd(input logic f);
    if (f !== 1'b1) begin
      miscompares++;
      conclude();
    end
  endtask : okd

  task automatic wait_acks(input int n);
    for (int i = 0; i < 40 && acks < n; i++) @(negedge clk);
    okd(acks >= n);
  endtask : wait_acks

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_decode;
    logic [ADDR_HI:1] a [4] = '{{BASE, 3'h0}, {BASE, 3'h7}, {BASE, 3'h3}, {BASE + 12'h1, 3'h0}};
    logic q [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
    logic e [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    for (int i = 0; i < 4; i++) begin
      h.sel(a[i], q[i], BE_ALL_N, 1'b1);
      #1 chk_bit(local_select_n, e[i]);
    end
    $display("test decode done");
  endtask : t_decode

  task automatic t_async;
    h.sel({BASE, 3'h2}, 1'b0, BE_ALL_N, 1'b1);
    h.arw(1'b0, '0, rd, w, ok);
    okd(ok);
    chk_bit(w, 1'b1);
    chk_word(rd, RPAT);
    chk_bit(last_cmd.wr, 1'b0);
    h.arw(1'b1, 32'hCAFE_F00D, rd, w, ok);
    okd(ok);
    wait_acks(acks + 1);
    chk_word(last_cmd.wdata, 32'hCAFE_F00D);
    chk_bit(last_cmd.wr, 1'b1);
    $display("test async done");
  endtask : t_async

  task automatic t_latch_dport;
    h.strobe(1'b1);
    h.sel({BASE + 12'h3, 3'h0}, 1'b1, 4'hA, 1'b1);
    #1 chk_bit(local_select_n, 1'b0);
    h.strobe(1'b0);
    #1 chk_bit(local_select_n, 1'b1);
    h.sel({BASE + 12'h3, 3'h0}, 1'b1, 4'hA, 1'b0);
    h.arw(1'b0, '0, rd, w, ok);
    okd(ok);
    chk_bit(last_cmd.dport, 1'b1);
    chk_word(32'(last_cmd.be), 32'(BE_ALL));
    $display("test latch and data port done");
  endtask : t_latch_dport

  task automatic t_width;
    bus_width = BUS_W8;
    for (int i = 0; i < 2; i++) begin
      h.sel({BASE, 3'h1}, 1'b0, {3'h7, i[0]}, 1'b1);
      h.arw(1'b0, '0, rd, w, ok);
      okd(ok);
      chk_word(32'(last_cmd.be), i[0] ? 32'h8 : 32'h4);
      chk_word({16'h0, rd[15:0]}, {16'h0, RPAT[31:16]});
    end
    bus_width = BUS_W16;
    h.sel({BASE, 3'h1}, 1'b0, 4'hC, 1'b1);
    h.arw(1'b0, '0, rd, w, ok);
    okd(ok);
    chk_word({16'h0, rd[15:0]}, {16'h0, RPAT[31:16]});
    bus_width = BUS_W32;
    $display("test bus width done");
  endtask : t_width

  task automatic t_sync;
    logic held;
    cycle_style_sel = 1'b0;
    h.sel({BASE, 3'h4}, 1'b0, BE_ALL_N, 1'b1);
    h.lbx(1'b0, '0, rd, held, ok);
    okd(ok);
    chk_word(rd, RPAT);
    chk_bit(held, 1'b1);
    chk_bit(last_cmd.wr, 1'b0);
    h.lbx(1'b1, 32'h0BAD_BEEF, rd, held, ok);
    okd(ok);
    chk_bit(last_cmd.wr, 1'b1);
    chk_word(last_cmd.wdata, 32'h0BAD_BEEF);
    chk_bit(held, 1'b1);
    cycle_style_sel = 1'b1;
    h.sel({BASE + 12'h3, 3'h0}, 1'b1, BE_NONE_N, 1'b0);
    h.brd(rd, held, ok);
    okd(ok);
    chk_word(rd, RPAT);
    chk_bit(held, 1'b1);
    h.sel({BASE + 12'h3, 3'h0}, 1'b1, BE_NONE_N, 1'b1);
    $display("test synchronous done");
  endtask : t_sync

  initial begin
    arst_n = 0;
    bus_width = BUS_W32;
    cycle_style_sel = 1'b0;
    repeat (8) @(negedge clk);
    arst_n = 1;
    t_decode();
    t_async();
    t_latch_dport();
    t_width();
    t_sync();
    conclude();
  end
endmodule : tb
